/* File: verilog/osp_status.sv */
// One-shot pulse done flags register bank, APB slave
// Behaviour
// - Sixteen flags, bit 15 for counter p down to bit 0 for counter a.
// - A flag is set to 1 when its down-counter underflows.
// - A flag clears only on a written 0 after it was read as 1, and resets to 0.
// - Writing 1 to a flag bit does nothing.
// - All sixteen flags read back their current value at any time.
`timescale 1ns/1ps
`include "osp_params.svh"
module osp_status #(
	parameter int NFLAGS = `OSP_FLAG_COUNT
) (
	// Clock and reset
	input  wire logic                   pclk,
	input  wire logic                   presetn,
	// APB slave
	input  wire osp_pkg::osp_apb_req_t  apb_req,
	output logic [31:0]                 prdata,
	output logic                        pready,
	output logic                        pslverr,
	// Underflow pulses from the down-counters, same clock
	input  wire logic [NFLAGS-1:0]      counter_underflow,
	// Flag levels for the rest of the timer
	output logic [NFLAGS-1:0]           pulse_done_flags
);
	initial
	begin
		if (NFLAGS != `OSP_FLAG_COUNT)
			$error("osp_status serves exactly sixteen flags");
	end

	logic [NFLAGS-1:0] flag_q;
	logic [NFLAGS-1:0] flag_d;
	logic [NFLAGS-1:0] armed_q;
	logic [NFLAGS-1:0] armed_d;
	logic [31:0]       prdata_d;
	logic              pready_q;
	logic              pslverr_q;
	logic [31:0]       prdata_q;

	wire logic setup_w   = apb_req.psel & ~apb_req.penable;
	wire logic access_w  = apb_req.psel & apb_req.penable & pready_q;
	wire logic hit_w     = (apb_req.paddr == `OSP_DONE_STATUS_OFS);
	wire logic rd_hit_w  = access_w & ~apb_req.pwrite & hit_w;
	wire logic wr_hit_w  = access_w & apb_req.pwrite & hit_w;
	wire logic [NFLAGS-1:0] wzero_w = ~apb_req.pwdata[NFLAGS-1:0];

	// Arm, clear and set per flag
	genvar g;
	generate
		for (g = 0; g < NFLAGS; g++)
		begin : g_flag
			wire logic clr_w = wr_hit_w & wzero_w[g] & armed_q[g];
			// armed by a returned 1
			// Arms on the value software saw, not a flag set after the setup sample
			assign armed_d[g] = clr_w ? 1'b0 : ((rd_hit_w & prdata_q[g]) | armed_q[g]);
			assign flag_d[g]  = counter_underflow[g] | (flag_q[g] & ~clr_w);
		end
	endgenerate

	assign prdata_d = (setup_w & ~apb_req.pwrite & hit_w) ?
		{{(32-NFLAGS){1'b0}}, flag_q} : 32'h0000_0000;

	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			flag_q  <= NFLAGS'(`OSP_DONE_STATUS_RST);
			armed_q <= '0;
		end
		else
		begin
			flag_q  <= flag_d;
			armed_q <= armed_d;
		end
	end

	// No wait state: answer in the cycle after setup
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			pready_q  <= 1'b0;
			pslverr_q <= 1'b0;
			prdata_q  <= 32'h0000_0000;
		end
		else
		begin
			pready_q  <= setup_w;
			pslverr_q <= setup_w & ~hit_w;
			prdata_q  <= prdata_d;
		end
	end

	assign prdata           = prdata_q;
	assign pready           = pready_q;
	assign pslverr          = pslverr_q;
	assign pulse_done_flags = flag_q;

	set_on_uflow_a: assert property (@(posedge pclk) disable iff (!presetn)
		counter_underflow[0] |=> flag_q[0]) else $error("flag a not set");
	// clear needs prior read of 1
	clear_needs_arm_a: assert property (@(posedge pclk) disable iff (!presetn)
		(flag_q[0] && !armed_q[0]) |=> flag_q[0]) else $error("flag cleared unarmed");
	write_one_nop_a: assert property (@(posedge pclk) disable iff (!presetn)
		(wr_hit_w && apb_req.pwdata[1] && !counter_underflow[1]) |=>
		flag_q[1] == $past(flag_q[1])) else $error("write 1 changed flag");
	read_back_a: assert property (@(posedge pclk) disable iff (!presetn)
		(setup_w && !apb_req.pwrite && hit_w && counter_underflow == 16'h0000) |=>
		prdata[15:0] == flag_q) else $error("read data mismatch");
	set_wins_a: assert property (@(posedge pclk) disable iff (!presetn)
		(wr_hit_w && armed_q[2] && !apb_req.pwdata[2] && counter_underflow[2]) |=>
		flag_q[2]) else $error("event lost on clear");
	armed_clear_a: assert property (@(posedge pclk) disable iff (!presetn)
		(wr_hit_w && armed_q[3] && !apb_req.pwdata[3] && !counter_underflow[3]) |=>
		!flag_q[3]) else $error("armed clear ignored");
	bit_p_map_a: assert property (@(posedge pclk) disable iff (!presetn)
		counter_underflow[15] |=> pulse_done_flags[15]) else $error("bit 15 map");
	upper_zero_a: assert property (@(posedge pclk) disable iff (!presetn)
		prdata[31:16] == 16'h0000) else $error("reserved bits nonzero");

	// Same checks on every flag, so a wrong bit index cannot hide
	genvar k;
	generate
		for (k = 0; k < NFLAGS; k++)
		begin : g_check
			each_set_a: assert property (@(posedge pclk) disable iff (!presetn)
				counter_underflow[k] |=> flag_q[k]) else $error("flag not set");
			no_spurious_a: assert property (@(posedge pclk) disable iff (!presetn)
				(!flag_q[k] && !counter_underflow[k]) |=> !flag_q[k])
				else $error("flag set without underflow");
			flag_hold_a: assert property (@(posedge pclk) disable iff (!presetn)
				(flag_q[k] && !(wr_hit_w && armed_q[k] && !apb_req.pwdata[k])) |=>
				flag_q[k]) else $error("flag dropped");
			each_clear_a: assert property (@(posedge pclk) disable iff (!presetn)
				(wr_hit_w && armed_q[k] && !apb_req.pwdata[k] && !counter_underflow[k]) |=>
				(!flag_q[k] && !armed_q[k])) else $error("armed clear failed");
			arm_source_a: assert property (@(posedge pclk) disable iff (!presetn)
				(!armed_q[k] && !(rd_hit_w && prdata_q[k])) |=> !armed_q[k])
				else $error("armed without read");
			each_wins_a: assert property (@(posedge pclk) disable iff (!presetn)
				(wr_hit_w && armed_q[k] && !apb_req.pwdata[k] && counter_underflow[k]) |=>
				flag_q[k]) else $error("event lost");
			each_map_a: assert property (@(posedge pclk) disable iff (!presetn)
				counter_underflow[k] |=> pulse_done_flags[k]) else $error("bit map");
		end
	endgenerate

	ready_after_a: assert property (@(posedge pclk) disable iff (!presetn)
		setup_w |=> pready) else $error("pready late");
	ready_pulse_a: assert property (@(posedge pclk) disable iff (!presetn)
		pready |=> !pready) else $error("pready held");
	ready_cause_a: assert property (@(posedge pclk) disable iff (!presetn)
		!setup_w |=> !pready) else $error("pready without setup");
	err_ready_a: assert property (@(posedge pclk) disable iff (!presetn)
		pslverr |-> pready) else $error("pslverr alone");
	err_unmapped_a: assert property (@(posedge pclk) disable iff (!presetn)
		(setup_w && !hit_w) |=> (pslverr && prdata == 32'h0000_0000))
		else $error("unmapped not refused");
	err_mapped_a: assert property (@(posedge pclk) disable iff (!presetn)
		(setup_w && hit_w) |=> !pslverr) else $error("mapped access refused");
	data_idle_a: assert property (@(posedge pclk) disable iff (!presetn)
		!pready |-> prdata == 32'h0000_0000) else $error("prdata not idle");
	write_nodata_a: assert property (@(posedge pclk) disable iff (!presetn)
		(setup_w && apb_req.pwrite) |=> prdata == 32'h0000_0000)
		else $error("write returned data");
	wr_unmapped_a: assert property (@(posedge pclk) disable iff (!presetn)
		(access_w && apb_req.pwrite && !hit_w && counter_underflow == 16'h0000) |=>
		flag_q == $past(flag_q)) else $error("unmapped write acted");
endmodule // osp_status

/* File: verilog/osp_params.svh */
// Register offsets, reset values and widths for the one-shot status bank
`ifndef OSP_PARAMS_SVH
`define OSP_PARAMS_SVH
`define OSP_DONE_STATUS_OFS   12'h000
`define OSP_DONE_STATUS_RST   16'h0000
`define OSP_FLAG_COUNT        16
`define OSP_ADDR_W            12
`endif

/* File: verilog/osp_pkg.sv */
// Types shared by the one-shot status bank
package osp_pkg;
	typedef struct packed {
		logic        psel;
		logic        penable;
		logic        pwrite;
		logic [11:0] paddr;
		logic [31:0] pwdata;
	} osp_apb_req_t;
	typedef enum logic {
		OSP_IDLE,
		OSP_DONE
	} osp_phase_t;
endpackage

/* File: verif/osp_status_test.sv */
// Random and corner tests of the done flag bank
`timescale 1ns/1ps
module osp_status_test;
	logic                  pclk, presetn, rdy, err, erv;
	osp_pkg::osp_apb_req_t rq;
	logic [31:0]           rd, rdv, seed;
	logic [15:0]           uf, fl, e, m, a, c;
	int                    num_errors, num_checks;
	osp_status DUT (.pclk(pclk), .presetn(presetn), .apb_req(rq), .prdata(rd),
		.pready(rdy), .pslverr(err), .counter_underflow(uf), .pulse_done_flags(fl));
	function automatic logic [31:0] xs(input logic [31:0] s);
		s ^= s << 13;
		s ^= s >> 17;
		return s ^ (s << 5);
	endfunction
	// Bits that a mapped write clears: armed by a read of 1, written 0
	function automatic logic [15:0] clr_of(input logic [15:0] arm, input logic [15:0] d);
		return arm & ~d;
	endfunction
	task chk(input logic [31:0] got, input logic [31:0] exp);
		num_checks++;
		if (got !== exp)
		begin
			num_errors++;
			$display("MISMATCH %0t got %h exp %h", $time, got, exp);
		end
	endtask
	// Underflow pulse u rides the access cycle, so it meets the write
	task apb(input logic w, input logic [11:0] a, input logic [15:0] d, input logic [15:0] u);
		int n;
		rq <= '{1'b1, 1'b0, w, a, {16'h0000, d}};
		@(posedge pclk);
		rq.penable <= 1'b1;
		uf <= u;
		n = 0;
		do
		begin
			@(posedge pclk);
			n++;
		end while (rdy !== 1'b1 && n < 20);
		if (rdy !== 1'b1)
			num_errors++;
		rdv = rd;
		erv = err;
		rq <= '0;
		uf <= '0;
		@(posedge pclk);
	endtask
	task give_verdict;
		if (num_errors == 0 && num_checks > 0)
			$display("TB: PASS");
		else
			$display("TB: FAIL");
		$finish;
	endtask
	initial
	begin
		pclk = 1'b0;
		forever #4 pclk = ~pclk;
	end
	initial
	begin
		#40000;
		num_errors++;
		give_verdict;
	end
	initial
	begin
		presetn = 1'b0; rq = '0; uf = '0; e = '0; a = '0; c = '0; seed = 32'hF30D;
		repeat (8) @(posedge pclk);
		presetn <= 1'b1;
		@(posedge pclk);
		chk(fl, 16'h0000);
		for (int i = 0; i < 6; i++)
		begin
			seed = xs(seed);
			m = seed[15:0] | 16'h8001;
			e |= m;
			apb(1'b1, 12'h004, 16'h0000, m);
			chk({erv, fl}, {1'b1, e});
			apb(1'b1, 12'h000, 16'hFFFF, 16'h0000);
			chk(fl, e);
			apb(1'b1, 12'h000, 16'h0000, 16'h0000);
			c = clr_of(a, 16'h0000);
			e &= ~c;
			a &= ~c;
			chk(fl, e);
			apb(1'b0, 12'h000, 16'h0000, 16'h0000);
			chk(rdv, {16'h0000, e});
			chk({31'h0, erv}, 32'h0000_0000);
			a |= e;
			seed = xs(seed);
			apb(1'b1, 12'h000, ~seed[15:0], 16'h0000);
			c = clr_of(a, ~seed[15:0]);
			e &= ~c;
			a &= ~c;
			chk(fl, e);
			apb(1'b0, 12'h004, 16'h0000, 16'h0000);
			chk(rdv, 32'h0000_0000);
			chk({31'h0, erv}, 32'h0000_0001);
		end
		apb(1'b1, 12'h004, 16'h0000, 16'h8001);
		e |= 16'h8001;
		apb(1'b0, 12'h000, 16'h0000, 16'h0000);
		chk(rdv[15:0], e);
		a |= e;
		apb(1'b1, 12'h000, 16'h0000, 16'h0001);
		chk(fl, 16'h0001);
		give_verdict;
	end
endmodule // osp_status_test
